// >>> vip_prioritizer.sv
// vectored interrupt prioritizer: classes, slot priority, vector address
// assumes request lines come from logic on clk_sys_i, single clock domain
//
// The strobed register port and the placing of the registers are this design's own decisions.
`include "vip_defs.svh"

// How it works
// - each request channel is enabled, then classed fast or normal, vectored or not
// - fast outranks vectored normal, which outranks non-vectored normal
// - all fast-class requests are ORed into one fast output
// - a status word shows which fast sources are requesting
// - sixteen vectored slots, any source, slot 0 highest, slot 15 lowest
// - normal output asserted when any normal-class request is active
// - vector register gives top requesting slot address, else default address
// - a status word shows which normal-class requests are active
// - each peripheral gives one line, the OR of its internal flags
// - ch0 watchdog, ch1 software only, ch2/3 debug comm receive/transmit
// - ch4 first timer, ch5 second timer combined requests
// - ch6 first serial port, ch7 second serial port with modem status
// - ch8 pulse-width, ch9 two-wire, ch10/11 synchronous serial ports
// - ch12 multiplier lock, ch13 real-time clock increment and alarm
// - ch14 to ch17 external requests zero to three in order
// - ch18 converter, ch19 to ch23 bus controllers and filter
module vip_prioritizer #(
  parameter int NUM_SLOT = 16
) (
  input  wire logic            clk_sys_i,
  input  wire logic            srst_i,
  input  wire vip_pkg::vip_src_t src_i,
  input  wire vip_pkg::vip_bus_t bus_i,
  output logic [31:0]          rd_data_o,
  output logic                 fast_interrupt_o,
  output logic                 normal_interrupt_o
);
  import vip_pkg::*;

  // struct has no field for the software channel, so one more
  localparam int NCH = $bits(vip_src_t) + 1;

  // ***********************************
  // elaboration checks
  // ***********************************
  if (NUM_SLOT < 1 || NUM_SLOT > 16) begin : g_chk
    $error("NUM_SLOT must be 1 to 16");
  end

  // ***********************************
  // decode helper
  // ***********************************
  // slot window hit: base + 4*n, n below NUM_SLOT
  function automatic logic slot_hit(input logic [11:0] a,
                                    input logic [11:0] base);
    slot_hit = (a[11:8] == base[11:8]) && (a[1:0] == 2'b00) &&
               (32'(a[7:2]) < NUM_SLOT);
  endfunction

  // ***********************************
  // state
  // ***********************************
  logic [NCH-1:0] enable_r,  enable_nxt;
  logic [NCH-1:0] class_r,   class_nxt;
  logic           soft_r,    soft_nxt;
  logic [31:0]    dflt_r,    dflt_nxt;
  logic [31:0]    rdat_r,    rdat_nxt;
  logic           fast_r,    fast_nxt;
  logic           norm_r,    norm_nxt;
  logic [31:0]    saddr_r   [NUM_SLOT];
  logic [31:0]    saddr_nxt [NUM_SLOT];
  vip_slot_t      sctl_r    [NUM_SLOT];
  vip_slot_t      sctl_nxt  [NUM_SLOT];

  logic [NCH-1:0] raw;
  logic [NCH-1:0] fast_stat;
  logic [NCH-1:0] norm_stat;
  logic [NUM_SLOT-1:0] slot_req;
  logic [31:0]    vect_addr;
  logic [3:0]     sidx;

  // ***********************************
  // channel map
  // ***********************************
  // software channel has no hardware source by design
  always_comb begin
    raw     = '0;
    raw[0]  = src_i.watchdog_request;
    raw[1]  = soft_r;
    raw[2]  = src_i.debug_comm_receive;
    raw[3]  = src_i.debug_comm_transmit;
    raw[4]  = src_i.timer0_req;
    raw[5]  = src_i.timer1_req;
    raw[6]  = src_i.uart0_req;
    raw[7]  = src_i.uart1_req;
    raw[8]  = src_i.pwm_req;
    raw[9]  = src_i.twi_req;
    raw[10] = src_i.ssp0_req;
    raw[11] = src_i.ssp1_req;
    raw[12] = src_i.lock_req;
    raw[13] = src_i.rtc_req;
    raw[17:14] = src_i.ext_req;
    raw[18] = src_i.adc_req;
    raw[23:19] = src_i.can_req;
  end
  // peripherals already OR their flags onto one line

  // ***********************************
  // classification and priority
  // ***********************************
  always_comb begin
    fast_stat = raw & enable_r & class_r;
    norm_stat = raw & enable_r & ~class_r;
    for (int k = 0; k < NUM_SLOT; k++) begin
      slot_req[k] = sctl_r[k].en &&
                    (32'(sctl_r[k].src) < NCH) &&
                    norm_stat[sctl_r[k].src];
    end
    // scan low to high priority so slot 0 wins last
    vect_addr = dflt_r;
    sidx      = '0;
    for (int k = NUM_SLOT - 1; k >= 0; k--) begin
      if (slot_req[k]) begin
        vect_addr = saddr_r[k];
        sidx      = 4'(k);
      end
    end
  end

  // ***********************************
  // registers: next values
  // ***********************************
  always_comb begin
    enable_nxt = enable_r;
    class_nxt  = class_r;
    soft_nxt   = soft_r;
    dflt_nxt   = dflt_r;
    rdat_nxt   = '0;
    saddr_nxt  = saddr_r;
    sctl_nxt   = sctl_r;
    fast_nxt   = |fast_stat;
    norm_nxt   = |norm_stat;
    if (bus_i.wr) begin
      case (bus_i.addr)
        `VIP_OFS_ENABLE:    enable_nxt = bus_i.wdata[NCH-1:0];
        `VIP_OFS_CLASS_SEL: class_nxt  = bus_i.wdata[NCH-1:0];
        `VIP_OFS_SOFT_REQ:  soft_nxt   = bus_i.wdata[`VIP_SOFT_CH];
        `VIP_OFS_DFLT_ADDR: dflt_nxt   = bus_i.wdata;
        default: begin
          if (slot_hit(bus_i.addr, `VIP_OFS_SLOT_ADDR)) begin
            saddr_nxt[bus_i.addr[5:2]] = bus_i.wdata;
          end
          if (slot_hit(bus_i.addr, `VIP_OFS_SLOT_CTL)) begin
            sctl_nxt[bus_i.addr[5:2]].en  =
              bus_i.wdata[`VIP_SLOT_EN_BIT];
            sctl_nxt[bus_i.addr[5:2]].src =
              bus_i.wdata[`VIP_SLOT_SRC_MSB:0];
          end
        end
      endcase
    end
    if (bus_i.rd) begin
      case (bus_i.addr)
        `VIP_OFS_NORM_STAT: rdat_nxt = 32'(norm_stat);
        `VIP_OFS_FAST_STAT: rdat_nxt = 32'(fast_stat);
        `VIP_OFS_RAW_STAT:  rdat_nxt = 32'(raw);
        `VIP_OFS_ENABLE:    rdat_nxt = 32'(enable_r);
        `VIP_OFS_CLASS_SEL: rdat_nxt = 32'(class_r);
        `VIP_OFS_SOFT_REQ:  rdat_nxt = 32'(soft_r) << `VIP_SOFT_CH;
        `VIP_OFS_VECT_ADDR: rdat_nxt = vect_addr;
        `VIP_OFS_DFLT_ADDR: rdat_nxt = dflt_r;
        default: begin
          if (slot_hit(bus_i.addr, `VIP_OFS_SLOT_ADDR)) begin
            rdat_nxt = saddr_r[bus_i.addr[5:2]];
          end
          if (slot_hit(bus_i.addr, `VIP_OFS_SLOT_CTL)) begin
            rdat_nxt = 32'(sctl_r[bus_i.addr[5:2]]);
          end
        end
      endcase
    end
  end

  // ***********************************
  // registers: storage
  // ***********************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      enable_r <= '0;
      class_r  <= '0;
      soft_r   <= 1'b0;
      dflt_r   <= `VIP_RST_WORD;
      rdat_r   <= `VIP_RST_WORD;
      fast_r   <= 1'b0;
      norm_r   <= 1'b0;
      for (int k = 0; k < NUM_SLOT; k++) begin
        saddr_r[k] <= `VIP_RST_WORD;
        sctl_r[k]  <= `VIP_RST_SLOT_CTL;
      end
    end else begin
      enable_r <= enable_nxt;
      class_r  <= class_nxt;
      soft_r   <= soft_nxt;
      dflt_r   <= dflt_nxt;
      rdat_r   <= rdat_nxt;
      fast_r   <= fast_nxt;
      norm_r   <= norm_nxt;
      saddr_r  <= saddr_nxt;
      sctl_r   <= sctl_nxt;
    end
  end

  assign rd_data_o          = rdat_r;
  assign fast_interrupt_o   = fast_r;
  assign normal_interrupt_o = norm_r;

  // ***********************************
  // assertions
  // ***********************************
  // a channel never lands in both classes at once
  property p_class_split;
    @(posedge clk_sys_i) disable iff (srst_i)
      (fast_stat & norm_stat) == '0;
  endproperty
  a_class_split: assert property (p_class_split)
    else $error("channel in both classes");

  property p_fast_merge;
    @(posedge clk_sys_i) disable iff (srst_i)
      (|fast_stat) |=> fast_interrupt_o;
  endproperty
  a_fast_merge: assert property (p_fast_merge)
    else $error("fast output missed a fast request");

  property p_fast_stat_read;
    @(posedge clk_sys_i) disable iff (srst_i)
      (bus_i.rd && bus_i.addr == `VIP_OFS_FAST_STAT) |=>
        rd_data_o == 32'($past(fast_stat));
  endproperty
  a_fast_stat_read: assert property (p_fast_stat_read)
    else $error("fast status read wrong");

  property p_slot0_wins;
    @(posedge clk_sys_i) disable iff (srst_i)
      slot_req[0] |-> (vect_addr == saddr_r[0]) && (sidx == 4'h0);
  endproperty
  a_slot0_wins: assert property (p_slot0_wins)
    else $error("slot 0 did not win");

  property p_norm_level;
    @(posedge clk_sys_i) disable iff (srst_i)
      (|norm_stat) ##1 (|norm_stat) |-> normal_interrupt_o;
  endproperty
  a_norm_level: assert property (p_norm_level)
    else $error("normal output low with normal request");

  property p_dflt_vect;
    @(posedge clk_sys_i) disable iff (srst_i)
      (bus_i.rd && bus_i.addr == `VIP_OFS_VECT_ADDR && slot_req == '0)
        |=> rd_data_o == $past(dflt_r);
  endproperty
  a_dflt_vect: assert property (p_dflt_vect)
    else $error("default vector not returned");

  property p_norm_stat_read;
    @(posedge clk_sys_i) disable iff (srst_i)
      (bus_i.rd && bus_i.addr == `VIP_OFS_NORM_STAT) |=>
        rd_data_o == 32'($past(norm_stat));
  endproperty
  a_norm_stat_read: assert property (p_norm_stat_read)
    else $error("normal status read wrong");

  property p_soft_ch;
    @(posedge clk_sys_i) disable iff (srst_i)
      (bus_i.wr && bus_i.addr == `VIP_OFS_SOFT_REQ) |=>
        raw[1] == $past(bus_i.wdata[`VIP_SOFT_CH]);
  endproperty
  a_soft_ch: assert property (p_soft_ch)
    else $error("software channel not set by write");

  property p_fast_drop;
    @(posedge clk_sys_i) disable iff (srst_i)
      (fast_stat == '0) |=> !fast_interrupt_o;
  endproperty
  a_fast_drop: assert property (p_fast_drop)
    else $error("fast output stuck high");

  // map checks go through the output, so a miswired channel shows
  property p_timer_map;
    @(posedge clk_sys_i) disable iff (srst_i)
      (src_i.timer0_req && enable_r[4] && !class_r[4]) ||
      (src_i.timer1_req && enable_r[5] && !class_r[5]) |=>
        normal_interrupt_o;
  endproperty
  a_timer_map: assert property (p_timer_map)
    else $error("timer channel map wrong");

  property p_norm_drop;
    @(posedge clk_sys_i) disable iff (srst_i)
      (norm_stat == '0) |=> !normal_interrupt_o;
  endproperty
  a_norm_drop: assert property (p_norm_drop)
    else $error("normal output stuck high");

  // one check per slot: a requesting slot beats every lower-ranked one
  for (genvar g = 0; g < NUM_SLOT; g++) begin : g_rank
    property p_slot_rank;
      @(posedge clk_sys_i) disable iff (srst_i)
        slot_req[g] && ((slot_req << (NUM_SLOT - g)) == '0) |->
          vect_addr == saddr_r[g];
    endproperty
    a_slot_rank: assert property (p_slot_rank)
      else $error("lower slot beat a higher one");
  end

  property p_wd_fast;
    @(posedge clk_sys_i) disable iff (srst_i)
      (src_i.watchdog_request && enable_r[0] && class_r[0]) |=>
        fast_interrupt_o;
  endproperty
  a_wd_fast: assert property (p_wd_fast)
    else $error("watchdog request lost");

  property p_ext_norm;
    @(posedge clk_sys_i) disable iff (srst_i)
      (|(src_i.ext_req & enable_r[17:14] & ~class_r[17:14])) |=>
        normal_interrupt_o;
  endproperty
  a_ext_norm: assert property (p_ext_norm)
    else $error("external request lost");

  property p_bus_norm;
    @(posedge clk_sys_i) disable iff (srst_i)
      (|(src_i.can_req & enable_r[23:19] & ~class_r[23:19])) |=>
        normal_interrupt_o;
  endproperty
  a_bus_norm: assert property (p_bus_norm)
    else $error("bus controller request lost");

  c_fast_two: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    $countones(fast_stat) > 1 ##1 fast_interrupt_o);
  c_slot_race: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    slot_req[0] && slot_req[NUM_SLOT-1]);
  c_dflt_read: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    bus_i.rd && bus_i.addr == `VIP_OFS_VECT_ADDR && slot_req == '0 &&
    (|norm_stat));
  c_soft_irq: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    norm_stat[1] ##1 normal_interrupt_o);
  c_low_slot: cover property (@(posedge clk_sys_i) disable iff (srst_i)
    slot_req[NUM_SLOT-1] && !slot_req[0]);

endmodule // vip_prioritizer

// >>> vip_defs.svh
// constants of the vectored interrupt prioritizer: offsets, fields, resets
// assumes a 32-bit word register port with byte addresses
`ifndef VIP_DEFS_SVH
`define VIP_DEFS_SVH

// ***********************************
// register offsets
// ***********************************
`define VIP_OFS_NORM_STAT   12'h000
`define VIP_OFS_FAST_STAT   12'h004
`define VIP_OFS_RAW_STAT    12'h008
`define VIP_OFS_ENABLE      12'h00c
`define VIP_OFS_CLASS_SEL   12'h010
`define VIP_OFS_SOFT_REQ    12'h014
`define VIP_OFS_VECT_ADDR   12'h018
`define VIP_OFS_DFLT_ADDR   12'h01c
`define VIP_OFS_SLOT_ADDR   12'h100
`define VIP_OFS_SLOT_CTL    12'h200

// ***********************************
// fields
// ***********************************
`define VIP_SLOT_EN_BIT     5
`define VIP_SLOT_SRC_MSB    4
`define VIP_SOFT_CH         1

// ***********************************
// reset values
// ***********************************
`define VIP_RST_WORD        32'h0000_0000
`define VIP_RST_SLOT_CTL    6'h00

`endif

// >>> vip_pkg.sv
// types of the vectored interrupt prioritizer
// assumes vip_defs.svh is on the include path
package vip_pkg;

  // one request line per peripheral, already the OR of its own flags
  typedef struct packed {
    logic [4:0] can_req;
    logic       adc_req;
    logic [3:0] ext_req;
    logic       rtc_req;
    logic       lock_req;
    logic       ssp1_req;
    logic       ssp0_req;
    logic       twi_req;
    logic       pwm_req;
    logic       uart1_req;
    logic       uart0_req;
    logic       timer1_req;
    logic       timer0_req;
    logic       debug_comm_transmit;
    logic       debug_comm_receive;
    logic       watchdog_request;
  } vip_src_t;

  // per-slot control: enable and source channel
  typedef struct packed {
    logic       en;
    logic [4:0] src;
  } vip_slot_t;

  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } vip_bus_t;

endpackage : vip_pkg

// >>> vip_core_model.sv
// core side model: takes the fast and normal interrupt levels
// assumes single clock domain, levels registered by the prioritizer
module vip_core_model (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       fast_interrupt_i,
  input  wire logic       normal_interrupt_i,
  output logic [7:0]      fast_entries_o,
  output logic [7:0]      normal_entries_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fast_d_r;
  logic norm_d_r;
  // counts handler entries: one per rising level, level held = same entry
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      fast_d_r         <= 1'b0;
      norm_d_r         <= 1'b0;
      fast_entries_o   <= 8'h00;
      normal_entries_o <= 8'h00;
    end else begin
      fast_d_r <= fast_interrupt_i;
      norm_d_r <= normal_interrupt_i;
      if (fast_interrupt_i && !fast_d_r) begin
        fast_entries_o <= fast_entries_o + 8'h01;
      end
      if (normal_interrupt_i && !norm_d_r) begin
        normal_entries_o <= normal_entries_o + 8'h01;
      end
    end
  end
endmodule // vip_core_model

// >>> vip_tb.sv
// self-checking bench of the vectored interrupt prioritizer
// assumes vip_pkg, vip_defs.svh and vip_core_model compiled first
`include "vip_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vip_pkg::*;
  logic        clk_sys_i;
  logic        srst_i;
  vip_src_t    src_r;
  vip_bus_t    bus_r;
  logic [31:0] rd_data;
  logic        fast_irq;
  logic        norm_irq;
  logic [7:0]  fast_cnt;
  logic [7:0]  norm_cnt;
  int          failures;
  int          n_compared;
  int          cyc;

  vip_prioritizer dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .src_i(src_r), .bus_i(bus_r), .rd_data_o(rd_data),
    .fast_interrupt_o(fast_irq), .normal_interrupt_o(norm_irq));
  vip_core_model core (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .fast_interrupt_i(fast_irq), .normal_interrupt_i(norm_irq),
    .fast_entries_o(fast_cnt), .normal_entries_o(norm_cnt));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ***********************************
  // shared tasks
  // ***********************************
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    bus_r <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys_i);
    bus_r <= '0;
  endtask
  task automatic rd(input string what, input logic [11:0] a,
                    input logic [31:0] exp);
    @(posedge clk_sys_i);
    bus_r <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys_i);
    bus_r <= '0;
    @(negedge clk_sys_i);
    chk(what, exp, rd_data);
    @(negedge clk_sys_i);
    chk("rd_idle", 32'h0, rd_data);
  endtask
  // new levels, then two edges: one to sample, one registered stage
  task automatic drive(input logic [23:0] v);
    @(posedge clk_sys_i);
    // channel 1 has no pin: its bit is dropped
    src_r <= vip_src_t'({v[23:2], v[0]});
    repeat (2) @(posedge clk_sys_i);
  endtask
  task automatic lvl(input logic f, input logic n);
    @(negedge clk_sys_i);
    chk("fast_out", {31'h0, f}, {31'h0, fast_irq});
    chk("normal_out", {31'h0, n}, {31'h0, norm_irq});
  endtask

  // ***********************************
  // scenarios
  // ***********************************
  task automatic t_reset();
    for (int a = 0; a < 12'h024; a += 4) begin
      rd("reset_word", 12'(a), 32'h0);
    end
    rd("slot15_ctl", 12'h23c, 32'h0);
    rd("unmapped", 12'h300, 32'h0);
    lvl(1'b0, 1'b0);
    wr(`VIP_OFS_ENABLE, 32'hffff_ffff);
    rd("enable", `VIP_OFS_ENABLE, 32'h00ff_ffff);
    wr(`VIP_OFS_RAW_STAT, 32'h0000_ffff);
    rd("raw_ro", `VIP_OFS_RAW_STAT, 32'h0);
  endtask
  task automatic t_fast();
    logic [7:0] f0;
    f0 = fast_cnt;
    wr(`VIP_OFS_CLASS_SEL, 32'h0000_0201);
    drive(24'h000201);
    lvl(1'b1, 1'b0);
    rd("fast_stat", `VIP_OFS_FAST_STAT, 32'h0000_0201);
    drive(24'h000200);
    lvl(1'b1, 1'b0);
    drive(24'h000000);
    lvl(1'b0, 1'b0);
    drive(24'h000011);
    lvl(1'b1, 1'b1);
    rd("fast_stat", `VIP_OFS_FAST_STAT, 32'h0000_0001);
    rd("norm_stat", `VIP_OFS_NORM_STAT, 32'h0000_0010);
    drive(24'h000000);
    chk("fast_entries", 32'(f0 + 8'h02), 32'(fast_cnt));
  endtask
  task automatic t_vector();
    wr(`VIP_OFS_DFLT_ADDR, 32'h0000_1230);
    wr(`VIP_OFS_SLOT_CTL, 32'h0000_0026);
    wr(`VIP_OFS_SLOT_CTL + 12'h03c, 32'h0000_0027);
    wr(`VIP_OFS_SLOT_CTL + 12'h004, 32'h0000_0020);
    wr(`VIP_OFS_SLOT_CTL + 12'h008, 32'h0000_0008);
    wr(`VIP_OFS_SLOT_ADDR, 32'h0000_a000);
    wr(`VIP_OFS_SLOT_ADDR + 12'h03c, 32'h0000_b0f0);
    wr(`VIP_OFS_SLOT_ADDR + 12'h004, 32'h0000_c000);
    wr(`VIP_OFS_SLOT_ADDR + 12'h008, 32'h0000_e000);
    rd("slot15_ctl", 12'h23c, 32'h0000_0027);
    drive(24'h0000d0);
    lvl(1'b0, 1'b1);
    rd("vector", `VIP_OFS_VECT_ADDR, 32'h0000_a000);
    drive(24'h000090);
    rd("vector", `VIP_OFS_VECT_ADDR, 32'h0000_b0f0);
    drive(24'h000110);
    rd("vector", `VIP_OFS_VECT_ADDR, 32'h0000_1230);
    rd("norm_stat", `VIP_OFS_NORM_STAT, 32'h0000_0110);
    drive(24'h000011);
    rd("vector", `VIP_OFS_VECT_ADDR, 32'h0000_1230);
    drive(24'h000000);
    lvl(1'b0, 1'b0);
  endtask
  task automatic t_soft_enable();
    wr(`VIP_OFS_SOFT_REQ, 32'h0000_0002);
    @(posedge clk_sys_i);
    lvl(1'b0, 1'b1);
    rd("raw_soft", `VIP_OFS_RAW_STAT, 32'h0000_0002);
    wr(`VIP_OFS_SOFT_REQ, 32'h0000_0000);
    wr(`VIP_OFS_ENABLE, 32'h00ff_ffef);
    drive(24'h000010);
    lvl(1'b0, 1'b0);
    rd("norm_stat", `VIP_OFS_NORM_STAT, 32'h0);
    wr(`VIP_OFS_ENABLE, 32'h00ff_ffff);
  endtask
  task automatic t_map();
    vip_src_t s;
    for (int ch = 0; ch < 24; ch++) begin
      if (ch != `VIP_SOFT_CH) begin
        drive(24'h000001 << ch);
        rd("raw_ch", `VIP_OFS_RAW_STAT, 32'h1 << ch);
      end
    end
    s = '0;
    s.ext_req = 4'b0001;
    s.can_req = 5'b10000;
    drive({s[22:1], 1'b0, s[0]});
    rd("raw_named", `VIP_OFS_RAW_STAT, 32'h0080_4000);
    drive(24'h000000);
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    failures = 0;
    n_compared = 0;
    cyc = 0;
    srst_i = 1'b1;
    src_r = '0;
    bus_r = '0;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_reset();
    t_fast();
    t_vector();
    t_soft_enable();
    t_map();
    close_out();
  end
endmodule // testbench
